// ===== dv/tb_top.sv
// Self-checking bench of the converter done-flag and input-enable block.
// Assumes adf_pkg is compiled first; the bench drives every input of the block itself.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import adf_pkg::*;

    // ------------------------------------------------------------
    // Ports of the block
    // ------------------------------------------------------------
    logic sys_clk = 1'b0; // 100 MHz system clock.
    logic arst_n = 1'b0; // Asynchronous reset, active low.
    logic ce = 1'b1; // Clock enable, dropped once to test the freeze.
    adf_wb_req_t wbReq = '0; // Bus request.
    logic wbAck;
    logic [ADF_DATA_W-1:0] wbDatO;
    adf_conv_t convIn = '0; // Finished conversion from the sequencer.
    logic seqStartPulse;
    logic extTrigEnable = 1'b0;
    logic [ADF_POS_W-1:0] extTrigChan = 4'h0;
    logic [ADF_BANK_W-1:0] analogPinLevel = 8'h00;
    logic [ADF_BANK_W-1:0] bufferEnable;
    logic [ADF_BANK_W-1:0] portInputBit;
    logic irq;

    // ------------------------------------------------------------
    // Reference model and bookkeeping
    // ------------------------------------------------------------
    int error_cnt = 0;
    int compares = 0;
    int starts = 0; // Start writes issued.
    int startCnt = 0; // Start pulses seen.
    logic [15:0] flags = '0; // Expected done flags.
    logic [15:0] armed = '0; // Flags armed by a status read.
    logic [15:0] res [16]; // Expected result store.
    logic [7:0] bufEn = '0;
    logic [7:0] lastStart = '0;
    logic [1:0] irqSts = '0;
    logic [1:0] mask = '0;
    logic fast = 1'b0;
    logic [31:0] rd; // Data taken at the ack edge.
    adf_conv_t pend = '0; // Conversion to launch with the next request.

    adf_done_flags dut_u (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .wbReq(wbReq),
        .wbAck(wbAck),
        .wbDatO(wbDatO),
        .convIn(convIn),
        .seqStartPulse(seqStartPulse),
        .extTrigEnable(extTrigEnable),
        .extTrigChan(extTrigChan),
        .analogPinLevel(analogPinLevel),
        .bufferEnable(bufferEnable),
        .portInputBit(portInputBit),
        .irq(irq)
    );

    // The clock toggles every half period.
    always #5 sys_clk = ~sys_clk;

    // Start pulses are counted so that a missing or doubled pulse shows.
    always @(posedge sys_clk) begin
        if (seqStartPulse === 1'b1) begin
            startCnt++;
        end
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Register reads, output levels and event counts each have their own compare.
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
        chk($sformatf("read %h", a), e, g);
    endtask

    task automatic chk_out(input string nm, input logic [7:0] e, input logic [7:0] g);
        chk(nm, {24'h0, e}, {24'h0, g});
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        chk(nm, 32'(e), 32'(g));
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Expected read value of a register from the model state.
    function automatic logic [31:0] expv(input logic [7:0] a);
        logic [7:0] g;
        for (int i = 0; i < 8; i++) begin
            g[i] = bufEn[i] | (extTrigEnable && extTrigChan == 4'(8 + i));
        end
        case (a)
            8'h00: return {24'h0, flags[7:0]};
            8'h04: return {24'h0, flags[15:8]};
            8'h08: return {24'h0, bufEn};
            8'h0c: return {31'h0, fast};
            8'h10: return {24'h0, lastStart};
            8'h14: return {24'h0, (analogPinLevel & g) | ~g};
            8'h18: return {30'h0, irqSts};
            8'h1c: return {30'h0, mask};
            default: return (a[7:6] == 2'h1) ? {16'h0, res[a[5:2]]} : 32'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus and sequencer drivers
    // ------------------------------------------------------------
    // One classic cycle; a pending conversion is launched at the same taking edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
        convIn <= pend;
        pend = '0;
        n = 0;
        do begin
            @(posedge sys_clk);
            convIn.valid <= 1'b0;
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatO;
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
        if (n >= 20) begin
            chk_cnt("ack", 1, 0);
        end
    endtask

    // Read, compare, then apply the read's side effects to the model.
    task automatic rdr(input logic [7:0] a);
        logic [31:0] e;
        e = expv(a);
        wb(1'b0, a, 32'h0);
        chk_rd(a, e, rd);
        if (a == 8'h00) begin
            armed[7:0] = armed[7:0] | flags[7:0];
        end
        if (a == 8'h04) begin
            armed[15:8] = armed[15:8] | flags[15:8];
        end
        if (a[7:6] == 2'h1 && (fast || armed[a[5:2]])) begin
            flags[a[5:2]] = 1'b0;
            armed[a[5:2]] = 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        case (a)
            8'h08: bufEn = d[7:0];
            8'h0c: fast = d[0];
            8'h10: begin
                flags = '0;
                armed = '0;
                irqSts[1] = 1'b1;
                lastStart = d[7:0];
                starts++;
            end
            8'h18: irqSts = irqSts & ~d[1:0];
            8'h1c: mask = d[1:0];
            default: ;
        endcase
    endtask

    task automatic conv(input logic [3:0] p, input logic [15:0] d);
        @(posedge sys_clk);
        convIn <= '{valid: 1'b1, pos: p, data: d};
        @(posedge sys_clk);
        convIn.valid <= 1'b0;
        flags[p] = 1'b1;
        res[p] = d;
        irqSts[0] = 1'b1;
    endtask

    // The interrupt output lags its status by a cycle, so two edges are allowed.
    task automatic chk_irq;
        repeat (2) @(posedge sys_clk);
        chk_out("irq", {7'h0, |(irqSts & mask)}, {7'h0, irq});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h864f304f));
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int a = 0; a <= 8'h20; a += 4) begin
            rdr(8'(a));
        end
        chk_out("bufferEnable", 8'h00, bufferEnable);
        for (int i = 0; i < 12; i++) begin
            conv(4'($urandom), 16'($urandom));
        end
        rdr(8'h00);
        rdr(8'h04);
        wr(8'h00, 32'hff);
        wr(8'h04, 32'hff);
        wr(8'h20, 32'hff);
        rdr(8'h00);
        rdr(8'h04);
        rdr(8'h20);
        // Slow clearing: a result read alone must not clear.
        wr(8'h10, $urandom);
        rdr(8'h04);
        conv(4'h3, 16'($urandom));
        conv(4'hc, 16'($urandom));
        rdr(8'h4c);
        rdr(8'h00);
        rdr(8'h70);
        rdr(8'h4c);
        rdr(8'h04);
        rdr(8'h70);
        rdr(8'h00);
        rdr(8'h04);
        // Fast clearing, then a set that meets a read clear.
        wr(8'h0c, 32'h1);
        conv(4'h5, 16'($urandom));
        conv(4'h9, 16'($urandom));
        rdr(8'h54);
        rdr(8'h64);
        rdr(8'h04);
        conv(4'h7, 16'h1234);
        pend = '{valid: 1'b1, pos: 4'h7, data: 16'h5678};
        wb(1'b0, 8'h5c, 32'h0);
        // The read is served before the new result lands at the same edge.
        chk_rd(8'h5c, 32'h1234, rd);
        res[7] = 16'h5678;
        rdr(8'h00);
        rdr(8'h5c);
        // A start write meeting a set: the clear must win.
        conv(4'h1, 16'($urandom));
        pend = '{valid: 1'b1, pos: 4'h2, data: 16'h0abc};
        wr(8'h10, 32'h5a);
        res[2] = 16'h0abc;
        irqSts[0] = 1'b1;
        rdr(8'h00);
        rdr(8'h48);
        chk_cnt("starts", starts, startCnt);
        // Interrupt: unmask, clear, raise again, mask.
        wr(8'h1c, 32'h3);
        chk_irq();
        rdr(8'h18);
        wr(8'h18, 32'h3);
        chk_irq();
        conv(4'h6, 16'($urandom));
        chk_irq();
        wr(8'h1c, 32'h2);
        chk_irq();
        rdr(8'h1c);
        // A low clock enable freezes the block: a finished conversion leaves no flag.
        @(posedge sys_clk);
        ce <= 1'b0;
        convIn <= '{valid: 1'b1, pos: 4'hb, data: 16'h0};
        @(posedge sys_clk);
        convIn.valid <= 1'b0;
        @(posedge sys_clk);
        ce <= 1'b1;
        rdr(8'h04);
        // Pin path with random enables, pins and trigger channel.
        for (int i = 0; i < 10; i++) begin
            analogPinLevel <= 8'($urandom);
            extTrigEnable <= 1'($urandom);
            extTrigChan <= 4'($urandom);
            wr(8'h08, $urandom);
            conv(4'($urandom), 16'($urandom));
            repeat (4) @(posedge sys_clk);
            chk_out("bufferEnable", bufEn, bufferEnable);
            chk_out("portInputBit", 8'(expv(8'h14)), portInputBit);
            rdr(8'h14);
            rdr(8'h08);
        end
        finish_test();
    end

    // A hang is cut short well beyond the few hundred cycles the run needs.
    initial begin
        #(20000 * 10);
        error_cnt++;
        finish_test();
    end

endmodule

`default_nettype wire

// ===== inc/adf_pkg.sv
// Shared constants and types of the converter done-flag and input-enable block.
// Assumes a 32-bit classic Wishbone slave port and one system clock.
package adf_pkg;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int ADF_DATA_W = 32; // Bus data width.
    localparam int ADF_ADDR_W = 8; // Byte address width of the window.
    localparam int ADF_CHANS = 16; // Sequence positions and result registers.
    localparam int ADF_POS_W = 4; // Width of a sequence position.
    localparam int ADF_BANK_W = 8; // Flags per status register.
    localparam int ADF_RES_W = 16; // Width of one stored result.
    localparam int ADF_IRQ_W = 2; // Number of interrupt events.
    localparam int ADF_SEL_W = ADF_DATA_W / 8; // Byte enables.

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_DONE_LOW = 8'h00;
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_DONE_HIGH = 8'h04;
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_BUF_EN_HIGH = 8'h08;
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_CTRL = 8'h0c;
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_SEQ_START = 8'h10;
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_PORT_IN = 8'h14;
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_IRQ_STS = 8'h18;
    localparam logic [ADF_ADDR_W-1:0] ADF_OFS_IRQ_MASK = 8'h1c;
    // Result registers occupy 8'h40..8'h7c, one word each.
    localparam logic [1:0] ADF_RES_WINDOW = 2'h1; // Value of address bits 7:6.

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int ADF_CTRL_FAST_BIT = 0; // Fast flag clear select.
    localparam int ADF_IRQ_DONE_BIT = 0; // A conversion completed.
    localparam int ADF_IRQ_START_BIT = 1; // A sequence was started.
    localparam logic [ADF_CHANS-1:0] ADF_FLAGS_RST = 16'h0000;
    localparam logic [ADF_CHANS-1:0] ADF_ONE_HOT_BASE = 16'h0001;
    localparam logic [ADF_BANK_W-1:0] ADF_BUF_EN_RST = 8'h00;
    localparam logic [ADF_BANK_W-1:0] ADF_PORT_RST = 8'hff;
    localparam logic [ADF_POS_W-1:0] ADF_PIN_BASE = 4'h8; // First pin handled here.

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // One finished conversion from the sequencer, valid for one cycle.
    typedef struct packed {
        logic valid;
        logic [ADF_POS_W-1:0] pos;
        logic [ADF_RES_W-1:0] data;
    } adf_conv_t;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADF_SEL_W-1:0] sel;
        logic [ADF_ADDR_W-1:0] adr;
        logic [ADF_DATA_W-1:0] dat;
    } adf_wb_req_t;

    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        ADF_BUS_IDLE = 2'b01,
        ADF_BUS_ACK = 2'b10
    } adf_bus_state_t;

endpackage

// ===== rtl/adf_done_flags.sv
// Conversion-done flags, result store and upper digital input enables of the converter.
// Assumes a classic Wishbone master and a sequencer on sys_clk; analog pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module adf_done_flags (
    // Clock, reset and freeze.
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Wishbone slave.
    input wire adf_pkg::adf_wb_req_t wbReq,
    output logic wbAck,
    output logic [adf_pkg::ADF_DATA_W-1:0] wbDatO,
    // Sequencer side.
    input wire adf_pkg::adf_conv_t convIn,
    output logic seqStartPulse,
    // External trigger selection, same clock.
    input wire logic extTrigEnable,
    input wire logic [adf_pkg::ADF_POS_W-1:0] extTrigChan,
    // Analog pins 15 to 8 and their digital path.
    input wire logic [adf_pkg::ADF_BANK_W-1:0] analogPinLevel,
    output logic [adf_pkg::ADF_BANK_W-1:0] bufferEnable,
    output logic [adf_pkg::ADF_BANK_W-1:0] portInputBit,
    // Interrupt.
    output logic irq
);

    import adf_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    adf_bus_state_t busState_q; // Slave state.
    adf_bus_state_t busState_d; // Next slave state.
    logic reqNew; // A new request is taken this cycle.
    logic busWr; // Taken write with the low byte lane on.
    logic busRd; // Taken read.
    logic hitLow, hitHigh, hitBuf, hitCtrl; // Address decode.
    logic hitStart, hitPort, hitSts, hitMask, hitRes;
    logic [ADF_POS_W-1:0] resIdx; // Result register addressed.
    logic [ADF_CHANS-1:0] flags_q; // Conversion done flags.
    logic [ADF_CHANS-1:0] flags_d;
    logic [ADF_CHANS-1:0] armed_q; // Flags seen by a status read.
    logic [ADF_CHANS-1:0] armed_d;
    logic [ADF_CHANS-1:0] setVec; // Flag set by the sequencer.
    logic [ADF_CHANS-1:0] rdClr; // Flag cleared by a result read.
    logic [ADF_CHANS-1:0] armNew; // Flags armed by this status read.
    logic startClr; // Sequence start write.
    logic fastClear_q; // Fast flag clear select.
    logic [ADF_BANK_W-1:0] seqCmd_q; // Last sequence start command.
    logic [ADF_BANK_W-1:0] bufEnHigh_q; // Digital input enables.
    logic [ADF_IRQ_W-1:0] irqSts_q; // Sticky interrupt status.
    logic [ADF_IRQ_W-1:0] irqMask_q; // Interrupt mask.
    logic [ADF_IRQ_W-1:0] irqEvt; // Events this cycle.
    logic [ADF_BANK_W-1:0] pinSync; // Synchronised pin levels.
    logic [ADF_BANK_W-1:0] trigHit; // Pin used as external trigger.
    logic [ADF_DATA_W-1:0] rdData; // Read multiplexer.
    logic [ADF_RES_W-1:0] resultMem [ADF_CHANS]; // Stored results.

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // A request is taken in IDLE; ACK follows for exactly one cycle, so
    // every access costs two cycles and the master must drop stb after ack.
    always_comb begin
        case (busState_q)
            ADF_BUS_IDLE: begin
                busState_d = (wbReq.cyc && wbReq.stb) ? ADF_BUS_ACK : ADF_BUS_IDLE;
            end
            ADF_BUS_ACK: begin
                busState_d = ADF_BUS_IDLE;
            end
            default: begin
                busState_d = ADF_BUS_IDLE;
            end
        endcase
    end

    // State and acknowledge are both flops; ack mirrors the ACK state.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_q <= ADF_BUS_IDLE;
            wbAck <= 1'b0;
        end else if (ce) begin
            busState_q <= busState_d;
            wbAck <= (busState_d == ADF_BUS_ACK);
        end
    end

    // Side effects happen once, at the edge where ack rises.
    assign reqNew = wbReq.cyc && wbReq.stb && (busState_q == ADF_BUS_IDLE);
    assign busWr = reqNew && wbReq.we && wbReq.sel[0];
    assign busRd = reqNew && !wbReq.we;

    // Full decode of the word addresses; anything else reads as zero.
    assign hitLow = (wbReq.adr == ADF_OFS_DONE_LOW);
    assign hitHigh = (wbReq.adr == ADF_OFS_DONE_HIGH);
    assign hitBuf = (wbReq.adr == ADF_OFS_BUF_EN_HIGH);
    assign hitCtrl = (wbReq.adr == ADF_OFS_CTRL);
    assign hitStart = (wbReq.adr == ADF_OFS_SEQ_START);
    assign hitPort = (wbReq.adr == ADF_OFS_PORT_IN);
    assign hitSts = (wbReq.adr == ADF_OFS_IRQ_STS);
    assign hitMask = (wbReq.adr == ADF_OFS_IRQ_MASK);
    assign hitRes = (wbReq.adr[7:6] == ADF_RES_WINDOW) && (wbReq.adr[1:0] == 2'h0);
    assign resIdx = wbReq.adr[5:2];

    // Read multiplexer. Status reads are allowed at any time.
    always_comb begin
        rdData = '0;
        if (hitLow) begin
            rdData = ADF_DATA_W'(flags_q[7:0]);
        end else if (hitHigh) begin
            rdData = ADF_DATA_W'(flags_q[15:8]);
        end else if (hitBuf) begin
            rdData = ADF_DATA_W'(bufEnHigh_q);
        end else if (hitCtrl) begin
            rdData = ADF_DATA_W'(fastClear_q);
        end else if (hitStart) begin
            rdData = ADF_DATA_W'(seqCmd_q);
        end else if (hitPort) begin
            rdData = ADF_DATA_W'(portInputBit);
        end else if (hitSts) begin
            rdData = ADF_DATA_W'(irqSts_q);
        end else if (hitMask) begin
            rdData = ADF_DATA_W'(irqMask_q);
        end else if (hitRes) begin
            rdData = ADF_DATA_W'(resultMem[resIdx]);
        end
    end

    // Read data is registered with ack and zero otherwise.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wbDatO <= '0;
        end else if (ce) begin
            wbDatO <= busRd ? rdData : '0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Writes to the done status registers reach no flop here, so they are
    // accepted and change nothing.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fastClear_q <= 1'b0;
            seqCmd_q <= '0;
            bufEnHigh_q <= ADF_BUF_EN_RST;
            irqMask_q <= '0;
        end else if (ce) begin
            if (busWr && hitCtrl) begin
                fastClear_q <= wbReq.dat[ADF_CTRL_FAST_BIT];
            end
            if (busWr && hitStart) begin
                seqCmd_q <= wbReq.dat[ADF_BANK_W-1:0];
            end
            if (busWr && hitBuf) begin
                bufEnHigh_q <= wbReq.dat[ADF_BANK_W-1:0];
            end
            if (busWr && hitMask) begin
                irqMask_q <= wbReq.dat[ADF_IRQ_W-1:0];
            end
        end
    end

    // Any write to the start register with the low byte lane on launches a sequence, whatever the data.
    assign startClr = busWr && hitStart;

    // The sequencer sees one pulse per start write.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            seqStartPulse <= 1'b0;
        end else if (ce) begin
            seqStartPulse <= startClr;
        end
    end

    // ----------------------------------------------------------------
    // Conversion done flags
    // ----------------------------------------------------------------
    // One-hot set vector from the finished conversion.
    assign setVec = convIn.valid ? (ADF_ONE_HOT_BASE << convIn.pos) : '0;

    // A status read arms only the flags it showed as set.
    always_comb begin
        armNew = '0;
        if (busRd && hitLow) begin
            armNew[7:0] = flags_q[7:0];
        end
        if (busRd && hitHigh) begin
            armNew[15:8] = flags_q[15:8];
        end
    end

    // A result read clears its flag at once in fast mode, or only
    // when armed by an earlier status read in slow mode.
    always_comb begin
        rdClr = '0;
        if (busRd && hitRes) begin
            if (fastClear_q) begin
                rdClr = ADF_ONE_HOT_BASE << resIdx;
            end else begin
                rdClr = (ADF_ONE_HOT_BASE << resIdx) & armed_q;
            end
        end
    end

    // Priority: start clear over set, set over read clear.
    always_comb begin
        if (startClr) begin
            flags_d = ADF_FLAGS_RST;
            armed_d = '0;
        end else begin
            flags_d = (flags_q & ~rdClr) | setVec;
            armed_d = (armed_q & ~rdClr) | armNew;
        end
    end

    // Flags and arming state.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= ADF_FLAGS_RST;
            armed_q <= '0;
        end else if (ce) begin
            flags_q <= flags_d;
            armed_q <= armed_d;
        end
    end

    // Results are data only and carry no reset; the flag says if valid.
    always_ff @(posedge sys_clk) begin
        if (ce && convIn.valid) begin
            resultMem[convIn.pos] <= convIn.data;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign irqEvt = {startClr, convIn.valid};

    // Sticky status, write one to clear; a new event wins over the clear.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqSts_q <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            if (busWr && hitSts) begin
                irqSts_q <= (irqSts_q & ~wbReq.dat[ADF_IRQ_W-1:0]) | irqEvt;
            end else begin
                irqSts_q <= irqSts_q | irqEvt;
            end
            irq <= |(irqSts_q & irqMask_q);
        end
    end

    // ----------------------------------------------------------------
    // Digital input path of pins 15 to 8
    // ----------------------------------------------------------------
    // Buffers follow the enable bits continuously; an analog pin with its
    // buffer on may draw extra current, which software must avoid.
    assign bufferEnable = bufEnHigh_q;

    // Pins are asynchronous and pass two flops first.
    adf_sync2 #(
        .WIDTH(ADF_BANK_W),
        .RST(ADF_PORT_RST)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .rawLevel(analogPinLevel),
        .syncLevel(pinSync)
    );

    // A pin selected as external trigger is always seen digitally.
    genvar gi;
    generate
        for (gi = 0; gi < ADF_BANK_W; gi++) begin : g_trig
            assign trigHit[gi] = extTrigEnable && (extTrigChan == ADF_PIN_BASE + ADF_POS_W'(gi));
        end
    endgenerate

    // A gated-off buffer reads as one.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portInputBit <= ADF_PORT_RST;
        end else if (ce) begin
            portInputBit <= pinSync | ~(bufEnHigh_q | trigHit);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_take;
        ce && reqNew;
    endsequence

    sequence s_ack_pulse;
        wbAck ##1 !wbAck;
    endsequence

    a_bus_ack_once: assert property (s_take |=> s_ack_pulse or !ce)
        else $error("ack is not a single-cycle answer");
    a_start_clears: assert property (ce && startClr |=> flags_q == ADF_FLAGS_RST)
        else $error("start write left a flag set");
    a_set_loses_start: assert property (ce && startClr && convIn.valid |=> flags_q == '0)
        else $error("set survived a start clear");
    a_set_flag: assert property (ce && convIn.valid && !startClr |=> flags_q[$past(convIn.pos)])
        else $error("finished conversion did not set its flag");
    a_set_beats_read: assert property (ce && !startClr && convIn.valid && (rdClr != '0) |=> flags_q[$past(convIn.pos)])
        else $error("read clear beat a set");
    a_fast_clear: assert property (s_take ##0 (!wbReq.we && hitRes && fastClear_q && !convIn.valid)
        |=> !flags_q[$past(resIdx)])
        else $error("fast mode result read did not clear");
    a_slow_needs_arm: assert property (s_take ##0 (!wbReq.we && hitRes && !fastClear_q && !armed_q[resIdx]
        && !convIn.valid) |=> flags_q == $past(flags_q))
        else $error("slow mode cleared without a status read");
    a_status_ro: assert property (s_take ##0 (wbReq.we && (hitLow || hitHigh)) |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("status write cleared a flag");
    a_low_read: assert property (s_take ##0 (!wbReq.we && hitLow) |=> wbDatO == ADF_DATA_W'($past(flags_q[7:0])))
        else $error("low status read wrong");
    a_high_read: assert property (s_take ##0 (!wbReq.we && hitHigh) |=> wbDatO == ADF_DATA_W'($past(flags_q[15:8])))
        else $error("high status read wrong");
    a_port_gated: assert property (ce && (bufEnHigh_q == '0) && !extTrigEnable |=> portInputBit == ADF_PORT_RST)
        else $error("gated port bit did not read one");

endmodule

`default_nettype wire

// ===== rtl/adf_sync2.sv
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes the pins change without regard to sys_clk; each bit is treated alone.
`timescale 1ns/100ps
`default_nettype none

module adf_sync2 #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST = '1
) (
    // Clock, reset and freeze.
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Raw and synchronised levels.
    input wire logic [WIDTH-1:0] rawLevel,
    output logic [WIDTH-1:0] syncLevel
);

    // First stage; only the second stage reads it.
    logic [WIDTH-1:0] meta_q;

    // Both stages take a constant under reset and hold while frozen.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= RST;
            syncLevel <= RST;
        end else if (ce) begin
            meta_q <= rawLevel;
            syncLevel <= meta_q;
        end
    end

endmodule

`default_nettype wire
